// ==== rtl/rcad_core.v ====
`include "rcad_map.vh"

module rcad_core (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire rc_mode_in,
  input wire [13:0] prog_data_in,
  input wire [7:0] data_rdata_in,
  output wire [12:0] prog_addr_out,
  output wire [7:0] data_addr_out,
  output wire [7:0] data_wdata_out,
  output wire data_we_out,
  output wire [7:0] work_reg_out,
  output wire [7:0] status_out,
  output wire [1:0] phase_out,
  output wire oscillator_output_pin_out,
  output wire oscillator_output_pin_oe_out
);

  ////////////////////////////////////////////////////////////////////////
  // State

  reg [12:0] pc_q;
  reg [13:0] ir_q;
  reg [7:0] w_q;
  reg [7:0] status_q;
  reg [7:0] fsr_q;
  reg [7:0] daddr_q;
  reg [7:0] dwdata_q;
  reg dwe_q;
  reg [`RCAD_SP_W-1:0] sp_q;
  reg [12:0] stack_q [0:`RCAD_STK_N-1];
  wire [1:0] phase;
  wire exec;

  function rcad_is_sfr;
    input [6:0] a;
    begin
      rcad_is_sfr = (a == `RCAD_SFR_INDF) || (a == `RCAD_SFR_PCL) ||
        (a == `RCAD_SFR_STATUS) || (a == `RCAD_SFR_FSR);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Instruction cycle timing and clock out

  rcad_clkdiv u_clkdiv (
    .ref_clk_in(ref_clk_in),
    .reset_n_in(reset_n_in),
    .rc_mode_in(rc_mode_in),
    .phase_out(phase),
    .pin_out(oscillator_output_pin_out),
    .pin_oe_out(oscillator_output_pin_oe_out)
  );

  assign exec = (phase == `RCAD_PH_EXEC);

  ////////////////////////////////////////////////////////////////////////
  // Decode

  wire [1:0] cls = ir_q[13:12];
  wire [3:0] bop = ir_q[11:8];
  wire dst = ir_q[7];
  wire [6:0] fa = ir_q[6:0];
  wire [2:0] bsel = ir_q[9:7];
  wire [7:0] lit = ir_q[7:0];
  wire [7:0] bmask = 8'h01 << bsel;

  // Direct uses bank bit plus field, indirect uses pointer
  wire [7:0] eff_a = (fa == `RCAD_SFR_INDF) ? fsr_q :
    {status_q[`RCAD_ST_BANK], fa};
  wire eff_sfr = rcad_is_sfr(eff_a[6:0]);

  reg [7:0] fval;
  always @* begin
    fval = data_rdata_in;
    if (eff_sfr) begin
      case (eff_a[6:0])
        `RCAD_SFR_PCL: fval = pc_q[7:0];
        `RCAD_SFR_STATUS: fval = status_q;
        `RCAD_SFR_FSR: fval = fsr_q;
        default: fval = 8'h00;
      endcase
    end
  end

  reg [3:0] alu_op;
  reg [7:0] alu_b;
  reg aff_c;
  reg aff_dc;
  reg aff_z;
  reg to_w;
  reg to_f;
  reg skip;
  reg jump;
  reg push;
  reg pop;
  wire [7:0] res;
  wire alu_c;
  wire alu_dc;
  wire alu_z;

  always @* begin
    alu_op = `RCAD_A_PASSB;
    alu_b = fval;
    aff_c = 1'b0;
    aff_dc = 1'b0;
    aff_z = 1'b0;
    to_w = 1'b0;
    to_f = 1'b0;
    skip = 1'b0;
    jump = 1'b0;
    push = 1'b0;
    pop = 1'b0;
    case (cls)
      `RCAD_CL_BYTE: begin
        // Result goes to file or working register
        to_f = dst;
        to_w = ~dst;
        case (bop)
          `RCAD_B_MOVWF: begin
            to_w = 1'b0;
            to_f = dst;
            alu_op = `RCAD_A_PASSA;
            pop = (ir_q == `RCAD_RETURN) || (ir_q == `RCAD_RETINT);
          end
          `RCAD_B_CLR: begin
            alu_op = `RCAD_A_CLR;
            aff_z = 1'b1;
          end
          `RCAD_B_SUB: begin
            alu_op = `RCAD_A_SUB;
            {aff_c, aff_dc, aff_z} = 3'h7;
          end
          `RCAD_B_DEC: begin
            alu_op = `RCAD_A_DEC;
            aff_z = 1'b1;
          end
          `RCAD_B_IOR: begin
            alu_op = `RCAD_A_IOR;
            aff_z = 1'b1;
          end
          `RCAD_B_AND: begin
            alu_op = `RCAD_A_AND;
            aff_z = 1'b1;
          end
          `RCAD_B_XOR: begin
            alu_op = `RCAD_A_XOR;
            aff_z = 1'b1;
          end
          `RCAD_B_ADD: begin
            alu_op = `RCAD_A_ADD;
            {aff_c, aff_dc, aff_z} = 3'h7;
          end
          `RCAD_B_MOVF: aff_z = 1'b1;
          `RCAD_B_COM: begin
            alu_op = `RCAD_A_COM;
            aff_z = 1'b1;
          end
          `RCAD_B_INC: begin
            alu_op = `RCAD_A_INC;
            aff_z = 1'b1;
          end
          `RCAD_B_DECSZ: begin
            alu_op = `RCAD_A_DEC;
            skip = alu_z;
          end
          `RCAD_B_RR: begin
            alu_op = `RCAD_A_RR;
            aff_c = 1'b1;
          end
          `RCAD_B_RL: begin
            alu_op = `RCAD_A_RL;
            aff_c = 1'b1;
          end
          `RCAD_B_SWAP: alu_op = `RCAD_A_SWAP;
          `RCAD_B_INCSZ: begin
            alu_op = `RCAD_A_INC;
            skip = alu_z;
          end
          default: alu_op = `RCAD_A_PASSB;
        endcase
      end
      `RCAD_CL_BIT: begin
        case (bop[3:2])
          `RCAD_BT_CLR: begin
            alu_b = fval & ~bmask;
            to_f = 1'b1;
          end
          `RCAD_BT_SET: begin
            alu_b = fval | bmask;
            to_f = 1'b1;
          end
          `RCAD_BT_TSC: skip = ~|(fval & bmask);
          `RCAD_BT_TSS: skip = |(fval & bmask);
          default: skip = 1'b0;
        endcase
      end
      `RCAD_CL_CTRL: begin
        jump = 1'b1;
        push = ~ir_q[11];
      end
      `RCAD_CL_LIT: begin
        alu_b = lit;
        to_w = 1'b1;
        casez (bop)
          4'b00??: alu_op = `RCAD_A_PASSB;
          4'b01??: pop = 1'b1;
          4'b1000: begin
            alu_op = `RCAD_A_IOR;
            aff_z = 1'b1;
          end
          4'b1001: begin
            alu_op = `RCAD_A_AND;
            aff_z = 1'b1;
          end
          4'b1010: begin
            alu_op = `RCAD_A_XOR;
            aff_z = 1'b1;
          end
          4'b110?: begin
            alu_op = `RCAD_A_SUB;
            {aff_c, aff_dc, aff_z} = 3'h7;
          end
          4'b111?: begin
            alu_op = `RCAD_A_ADD;
            {aff_c, aff_dc, aff_z} = 3'h7;
          end
          default: alu_op = `RCAD_A_PASSB;
        endcase
      end
      default: jump = 1'b0;
    endcase
  end

  rcad_alu u_alu (
    .alu_op_in(alu_op),
    .a_in(w_q),
    .b_in(alu_b),
    .c_in(status_q[`RCAD_ST_C]),
    .result_out(res),
    .c_out(alu_c),
    .dc_out(alu_dc),
    .z_out(alu_z)
  );

  ////////////////////////////////////////////////////////////////////////
  // Next program counter and status

  wire wr_sfr = to_f & eff_sfr;
  wire pcl_wr = wr_sfr & (eff_a[6:0] == `RCAD_SFR_PCL);
  // Any change of flow discards the word fetched alongside
  wire flush = jump | pop | pcl_wr | skip;
  wire [`RCAD_SP_W-1:0] sp_dec = sp_q - {{(`RCAD_SP_W-1){1'b0}}, 1'b1};

  reg [12:0] pc_d;
  reg [7:0] status_d;
  always @* begin
    if (pop) begin
      pc_d = stack_q[sp_dec];
    end else if (jump) begin
      pc_d = {pc_q[12:11], ir_q[10:0]};
    end else if (pcl_wr) begin
      pc_d = {pc_q[12:8], res};
    end else begin
      pc_d = pc_q + 13'h0001;
    end
    status_d = status_q;
    if (wr_sfr && (eff_a[6:0] == `RCAD_SFR_STATUS)) begin
      status_d = res;
    end
    // Flag updates win over a plain write of the status byte
    if (aff_c) begin
      status_d[`RCAD_ST_C] = alu_c;
    end
    if (aff_dc) begin
      status_d[`RCAD_ST_DC] = alu_dc;
    end
    if (aff_z) begin
      status_d[`RCAD_ST_Z] = alu_z;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Fetch and execute, overlapped

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      pc_q <= `RCAD_PC_RST;
      ir_q <= `RCAD_NOP;
      w_q <= `RCAD_W_RST;
      status_q <= `RCAD_STATUS_RST;
      fsr_q <= `RCAD_FSR_RST;
      sp_q <= {`RCAD_SP_W{1'b0}};
    end else if (exec) begin
      // Word at pc_q arrives while current one executes
      ir_q <= flush ? `RCAD_NOP : prog_data_in;
      pc_q <= pc_d;
      status_q <= status_d;
      if (to_w) begin
        w_q <= res;
      end
      if (wr_sfr && (eff_a[6:0] == `RCAD_SFR_FSR)) begin
        fsr_q <= res;
      end
      if (push) begin
        sp_q <= sp_q + {{(`RCAD_SP_W-1){1'b0}}, 1'b1};
      end else if (pop) begin
        sp_q <= sp_dec;
      end
    end
  end

  // Return stack, wraps when over-filled
  always @(posedge ref_clk_in) begin
    if (exec && push) begin
      stack_q[sp_q] <= pc_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Data memory port

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      daddr_q <= 8'h00;
      dwdata_q <= 8'h00;
      dwe_q <= 1'b0;
    end else begin
      if (phase == `RCAD_PH_ADDR) begin
        daddr_q <= eff_a;
        dwe_q <= 1'b0;
      end else if (exec) begin
        dwdata_q <= res;
        dwe_q <= to_f & ~eff_sfr;
      end
    end
  end

  assign prog_addr_out = pc_q;
  assign data_addr_out = daddr_q;
  assign data_wdata_out = dwdata_q;
  assign data_we_out = dwe_q;
  assign work_reg_out = w_q;
  assign status_out = status_q;
  assign phase_out = phase;

endmodule // rcad_core

// ==== rtl/rcad_map.vh ====
// Contract
// - Fetch one 14-bit word per cycle, own bus.
// - Separate program and 8-bit data buses.
// - Next fetch overlaps current execute.
// - One cycle per instruction, branches take two.
// - Special registers mapped in data; direct, indirect.
// - Any operation on any register, any mode.
// - 8-bit ALU: add, subtract, shift, logic.
// - Arithmetic in two's complement.
// - Two operands: working register plus file/literal.
// - One operand: working register or file.
// - 8-bit working register, not addressable.
// - ALU updates carry, digit carry, zero.
// - Subtract carries are inverted borrows.
// - RC mode drives quarter-rate clock out.
// - Held in reset while master clear low.
`ifndef RCAD_MAP_VH
`define RCAD_MAP_VH
// Widths
`define RCAD_PC_W 13
`define RCAD_IW 14
`define RCAD_DW 8
// Instruction phases, four per instruction cycle
`define RCAD_PH_EXEC 2'h3
`define RCAD_PH_ADDR 2'h0
`define RCAD_CLK_BIT 1
// Reset values
`define RCAD_NOP 14'h0000
`define RCAD_PC_RST 13'h0000
`define RCAD_STATUS_RST 8'h00
`define RCAD_FSR_RST 8'h00
`define RCAD_W_RST 8'h00
// Special register addresses, mirrored in every bank
`define RCAD_SFR_INDF 7'h00
`define RCAD_SFR_PCL 7'h02
`define RCAD_SFR_STATUS 7'h03
`define RCAD_SFR_FSR 7'h04
// Status bits
`define RCAD_ST_C 0
`define RCAD_ST_DC 1
`define RCAD_ST_Z 2
`define RCAD_ST_BANK 5
// Instruction classes
`define RCAD_CL_BYTE 2'h0
`define RCAD_CL_BIT 2'h1
`define RCAD_CL_CTRL 2'h2
`define RCAD_CL_LIT 2'h3
// Byte oriented operations
`define RCAD_B_MOVWF 4'h0
`define RCAD_B_CLR 4'h1
`define RCAD_B_SUB 4'h2
`define RCAD_B_DEC 4'h3
`define RCAD_B_IOR 4'h4
`define RCAD_B_AND 4'h5
`define RCAD_B_XOR 4'h6
`define RCAD_B_ADD 4'h7
`define RCAD_B_MOVF 4'h8
`define RCAD_B_COM 4'h9
`define RCAD_B_INC 4'hA
`define RCAD_B_DECSZ 4'hB
`define RCAD_B_RR 4'hC
`define RCAD_B_RL 4'hD
`define RCAD_B_SWAP 4'hE
`define RCAD_B_INCSZ 4'hF
// Bit operations, field [11:10]
`define RCAD_BT_CLR 2'h0
`define RCAD_BT_SET 2'h1
`define RCAD_BT_TSC 2'h2
`define RCAD_BT_TSS 2'h3
// Returns
`define RCAD_RETURN 14'h0008
`define RCAD_RETINT 14'h0009
// Stack
`define RCAD_SP_W 3
`define RCAD_STK_N 8
// ALU operation codes
`define RCAD_A_PASSB 4'h0
`define RCAD_A_PASSA 4'h1
`define RCAD_A_CLR 4'h2
`define RCAD_A_ADD 4'h3
`define RCAD_A_SUB 4'h4
`define RCAD_A_AND 4'h5
`define RCAD_A_IOR 4'h6
`define RCAD_A_XOR 4'h7
`define RCAD_A_COM 4'h8
`define RCAD_A_INC 4'h9
`define RCAD_A_DEC 4'hA
`define RCAD_A_RL 4'hB
`define RCAD_A_RR 4'hC
`define RCAD_A_SWAP 4'hD
`endif

// ==== rtl/rcad_alu.v ====
`include "rcad_map.vh"

module rcad_alu (
  input wire [3:0] alu_op_in,
  input wire [7:0] a_in,
  input wire [7:0] b_in,
  input wire c_in,
  output reg [7:0] result_out,
  output reg c_out,
  output reg dc_out,
  output wire z_out
);

  // Returns {digit carry, carry, sum}
  function [9:0] rcad_add;
    input [7:0] x;
    input [7:0] y;
    input ci;
    reg [4:0] lo;
    reg [4:0] hi;
    begin
      lo = {1'b0, x[3:0]} + {1'b0, y[3:0]} + {4'h0, ci};
      hi = {1'b0, x[7:4]} + {1'b0, y[7:4]} + {4'h0, lo[4]};
      rcad_add = {lo[4], hi[4], hi[3:0], lo[3:0]};
    end
  endfunction

  reg [9:0] sum;

  always @* begin
    sum = 10'h000;
    result_out = b_in;
    c_out = c_in;
    dc_out = 1'b0;
    case (alu_op_in)
      `RCAD_A_PASSB: result_out = b_in;
      `RCAD_A_PASSA: result_out = a_in;
      `RCAD_A_CLR: result_out = 8'h00;
      `RCAD_A_ADD: begin
        sum = rcad_add(b_in, a_in, 1'b0);
        {dc_out, c_out, result_out} = sum;
      end
      `RCAD_A_SUB: begin
        // File or literal minus working register; carries are inverted borrows
        sum = rcad_add(b_in, ~a_in, 1'b1);
        {dc_out, c_out, result_out} = sum;
      end
      `RCAD_A_AND: result_out = a_in & b_in;
      `RCAD_A_IOR: result_out = a_in | b_in;
      `RCAD_A_XOR: result_out = a_in ^ b_in;
      `RCAD_A_COM: result_out = ~b_in;
      `RCAD_A_INC: result_out = b_in + 8'h01;
      `RCAD_A_DEC: result_out = b_in - 8'h01;
      `RCAD_A_RL: {c_out, result_out} = {b_in, c_in};
      `RCAD_A_RR: {result_out, c_out} = {c_in, b_in};
      `RCAD_A_SWAP: result_out = {b_in[3:0], b_in[7:4]};
      default: result_out = b_in;
    endcase
  end

  assign z_out = (result_out == 8'h00);

endmodule // rcad_alu

// ==== rtl/rcad_clkdiv.v ====
`include "rcad_map.vh"

module rcad_clkdiv (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire rc_mode_in,
  output wire [1:0] phase_out,
  output wire pin_out,
  output wire pin_oe_out
);

  reg [1:0] phase_q;
  reg clk_q;
  reg oe_q;
  wire [1:0] phase_d;

  assign phase_d = phase_q + 2'h1;

  always @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      phase_q <= 2'h0;
      clk_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      // High for the last two phases of each instruction cycle
      clk_q <= phase_d[`RCAD_CLK_BIT] & rc_mode_in;
      oe_q <= rc_mode_in;
    end
  end

  assign phase_out = phase_q;
  assign pin_out = clk_q;
  assign pin_oe_out = oe_q;

endmodule // rcad_clkdiv

// ==== test/rcad_core_assertions.sv ====
module rcad_core_assertions (
  input wire ref_clk_in,
  input wire reset_n_in,
  input wire rc_mode_in,
  input wire [12:0] prog_addr_out,
  input wire [7:0] data_addr_out,
  input wire data_we_out,
  input wire [7:0] work_reg_out,
  input wire [7:0] status_out,
  input wire [1:0] phase_out,
  input wire oscillator_output_pin_out,
  input wire oscillator_output_pin_oe_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  sequence we_pulse_s;
    phase_out == 2'h0 ##1 !data_we_out;
  endsequence
  ////////////////////////////////////////
  phase_step_a: assert property (
    1 |=> phase_out == $past(phase_out) + 2'h1)
    else $error("phase did not advance");
  fetch_edge_a: assert property (
    $changed(prog_addr_out) |-> $past(phase_out) == 2'h3)
    else $error("fetch address moved off phase 3");
  fetch_adv_a: assert property (
    phase_out == 2'h3 |=> prog_addr_out != $past(prog_addr_out))
    else $error("no fetch in instruction cycle");
  exec_edge_a: assert property (
    $changed(work_reg_out) || $changed(status_out)
      |-> $past(phase_out) == 2'h3)
    else $error("result landed off phase 3");
  data_addr_a: assert property (
    $changed(data_addr_out) |-> $past(phase_out) == 2'h0)
    else $error("data address moved off phase 0");
  we_pulse_a: assert property (
    data_we_out |-> we_pulse_s)
    else $error("write strobe not a phase 0 pulse");
  we_inner_a: assert property (
    data_we_out |-> !(data_addr_out[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04}))
    else $error("write strobe for a core register");
  pin_rate_a: assert property (
    oscillator_output_pin_oe_out |-> oscillator_output_pin_out == phase_out[1])
    else $error("clock pin not at quarter rate");
  pin_off_a: assert property (
    !oscillator_output_pin_oe_out |-> !oscillator_output_pin_out)
    else $error("clock pin high while not driven");
  oe_track_a: assert property (
    1 |=> oscillator_output_pin_oe_out == $past(rc_mode_in))
    else $error("pin enable does not follow mode");
endmodule // rcad_core_assertions

bind rcad_core rcad_core_assertions rcad_core_assertions_i (
  .ref_clk_in(ref_clk_in),
  .reset_n_in(reset_n_in),
  .rc_mode_in(rc_mode_in),
  .prog_addr_out(prog_addr_out),
  .data_addr_out(data_addr_out),
  .data_we_out(data_we_out),
  .work_reg_out(work_reg_out),
  .status_out(status_out),
  .phase_out(phase_out),
  .oscillator_output_pin_out(oscillator_output_pin_out),
  .oscillator_output_pin_oe_out(oscillator_output_pin_oe_out)
);

// ==== test/rcad_mem_model.sv ====
module rcad_mem_model (
  input wire ref_clk_in,
  input wire [12:0] prog_addr_in,
  output wire [13:0] prog_data_out,
  input wire [7:0] data_addr_in,
  input wire [7:0] data_wdata_in,
  input wire data_we_in,
  output wire [7:0] data_rdata_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [13:0] prog_q [0:8191];
  logic [7:0] data_q [0:255];
  // Whole word per fetch on its own bus
  assign prog_data_out = prog_q[prog_addr_in];
  assign data_rdata_out = data_q[data_addr_in];
  always @(posedge ref_clk_in) begin
    if (data_we_in) begin
      data_q[data_addr_in] <= data_wdata_in;
    end
  end
endmodule // rcad_mem_model

// ==== test/rcad_core_tb.sv ====
module rcad_core_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic rc_mode_in = 1'b0;
  wire [13:0] prog_data;
  wire [12:0] prog_addr;
  wire [7:0] rdata, daddr, wdata, w_reg, status;
  wire we, pin, pin_oe;
  wire [1:0] phase;
  int num_errors = 0;
  int checks = 0;
  int we_count = 0;

  initial begin
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  rcad_core rcad_core_i (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .rc_mode_in(rc_mode_in), .prog_data_in(prog_data),
    .data_rdata_in(rdata), .prog_addr_out(prog_addr),
    .data_addr_out(daddr), .data_wdata_out(wdata), .data_we_out(we),
    .work_reg_out(w_reg), .status_out(status), .phase_out(phase),
    .oscillator_output_pin_out(pin),
    .oscillator_output_pin_oe_out(pin_oe));
  rcad_mem_model rcad_mem_model_i (.ref_clk_in(ref_clk_in),
    .prog_addr_in(prog_addr), .prog_data_out(prog_data),
    .data_addr_in(daddr), .data_wdata_in(wdata), .data_we_in(we),
    .data_rdata_out(rdata));

  always @(posedge ref_clk_in) begin
    if (we === 1'b1) begin
      we_count++;
    end
  end
  ////////////////////////////////////////
  task automatic check(input logic [13:0] seen, input logic [13:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic load(input logic [13:0] words[$]);
    for (int i = 0; i < 8192; i++) begin
      rcad_mem_model_i.prog_q[i] = (i < words.size()) ? words[i] : 14'h0000;
    end
  endtask

  task automatic do_reset();
    @(negedge ref_clk_in);
    reset_n_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    check(prog_addr, 14'h0000);
    check({we, pin_oe, w_reg}, 14'h0000);
    reset_n_in = 1'b1;
  endtask

  task automatic next_cycle();
    int n = 0;
    while (phase !== 2'h3 && n < 8) begin
      @(negedge ref_clk_in);
      n++;
    end
    @(negedge ref_clk_in);
  endtask
  ////////////////////////////////////////
  task automatic test_clock();
    rc_mode_in = 1'b1;
    do_reset();
    repeat (2) @(negedge ref_clk_in);
    for (int i = 0; i < 8; i++) begin
      @(negedge ref_clk_in);
      check({pin_oe, pin, phase}, {1'b1, ~(i[1] ^ i[0]), 2'(i + 3)});
    end
    rc_mode_in = 1'b0;
    repeat (2) @(negedge ref_clk_in);
    check({pin_oe, pin}, 14'h0000);
    $display("test_clock done");
  endtask

  task automatic test_arith();
    logic [7:0] w_exp[9] = '{8'h0F, 8'h10, 8'h00, 8'h05, 8'h06, 8'hFF,
      8'h0F, 8'h00, 8'h80};
    logic [2:0] st_exp[9] = '{3'h0, 3'h2, 3'h5, 3'h3, 3'h3, 3'h0, 3'h0,
      3'h4, 3'h0};
    load('{14'h300F, 14'h3E01, 14'h3EF0, 14'h3C05, 14'h3006, 14'h3C05,
      14'h390F, 14'h3A0F, 14'h3880});
    do_reset();
    next_cycle();
    check(prog_addr, 14'h0001);
    for (int i = 0; i < 9; i++) begin
      next_cycle();
      check(w_reg, w_exp[i]);
      check(status[2:0], st_exp[i]);
    end
    $display("test_arith done");
  endtask

  task automatic test_file();
    logic [7:0] w_exp[8] = '{8'h3A, 8'h3A, 8'h3A, 8'h3A, 8'hE9, 8'h20,
      8'h20, 8'h74};
    logic [2:0] st_exp[8] = '{3'h0, 3'h0, 3'h2, 3'h1, 3'h0, 3'h0, 3'h0,
      3'h0};
    load('{14'h303A, 14'h00A0, 14'h07A0, 14'h0220, 14'h0D20, 14'h3020,
      14'h0084, 14'h0800});
    do_reset();
    next_cycle();
    we_count = 0;
    for (int i = 0; i < 8; i++) begin
      next_cycle();
      check(w_reg, w_exp[i]);
      check(status[2:0], st_exp[i]);
    end
    check(rcad_mem_model_i.data_q[8'h20], 14'h0074);
    check(we_count, 14'h0002);
    $display("test_file done");
  endtask

  task automatic test_branch();
    load('{14'h2805, 14'h3011, 14'h0000, 14'h0000, 14'h0000, 14'h3055});
    do_reset();
    next_cycle();
    next_cycle();
    check(prog_addr, 14'h0005);
    next_cycle();
    check(prog_addr, 14'h0006);
    check(w_reg, 14'h0000);
    next_cycle();
    check(w_reg, 14'h0055);
    $display("test_branch done");
  endtask

  task automatic test_misc();
    logic [7:0] w_exp[19] = '{8'h81, 8'h81, 8'h81, 8'h04, 8'hBF, 8'hBF,
      8'hBF, 8'hBF, 8'hBF, 8'hBF, 8'hBF, 8'hBF, 8'hBF, 8'h42, 8'h42,
      8'h42, 8'hFF, 8'hFF, 8'hFF};
    logic [2:0] st_exp[19] = '{3'h0, 3'h0, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
      3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h5, 3'h1, 3'h1,
      3'h1};
    load('{14'h3081, 14'h00A1, 14'h0CA1, 14'h0E21, 14'h0921, 14'h2010,
      14'h0A21, 14'h0BA1, 14'h01A1, 14'h0321, 14'h1683, 14'h00A1, 14'h0000,
      14'h0000, 14'h0000, 14'h0000, 14'h1421, 14'h1821, 14'h1C21, 14'h30EE,
      14'h0008});
    do_reset();
    next_cycle();
    we_count = 0;
    for (int i = 0; i < 19; i++) begin
      next_cycle();
      check(w_reg, w_exp[i]);
      check(status[2:0], st_exp[i]);
    end
    // Let the last write strobe reach memory
    @(negedge ref_clk_in);
    check(prog_addr, 14'h000D);
    check(status, 14'h0021);
    check(rcad_mem_model_i.data_q[8'hA1], 14'h00FF);
    check(rcad_mem_model_i.data_q[8'h21], 14'h0000);
    check(we_count, 14'h0006);
    $display("test_misc done");
  endtask
  ////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    for (int i = 0; i < 256; i++) begin
      rcad_mem_model_i.data_q[i] = 8'h00;
    end
    test_clock();
    test_arith();
    test_file();
    test_branch();
    test_misc();
    wrap_up();
  end

  initial begin
    repeat (2000) @(posedge ref_clk_in);
    num_errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up();
  end
endmodule // rcad_core_tb
